// [rtl/usbc_cap_pkg.sv]
// Constants of the host controller capability register group.
// Assumes byte addresses built as {A[17:1], 1'b0} from the processor bus.
package usbc_cap_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam int         ADDR_W                = 18;            // Byte address width
  localparam int         DATA_W                = 32;            // Processor data width
  localparam logic [17:0] OFF_CAPABILITY_LENGTH = 18'h00000;    // Length byte
  localparam logic [17:0] OFF_INTERFACE_VERSION = 18'h00002;    // Version halfword
  localparam logic [17:0] OFF_STRUCTURAL_PARAMS = 18'h00004;    // Structural word
  localparam logic [17:0] OFF_CAPABILITY_PARAMS = 18'h00008;    // Capability word
  localparam logic [17:0] CAP_SPACE_END         = 18'h00020;    // First operational byte

  // ----------------------------------------------------------------
  // Word zero layout
  // ----------------------------------------------------------------
  localparam int         CAPLEN_LSB            = 0;             // Length byte position
  localparam int         VERSION_LSB           = 16;            // Version halfword position
  localparam logic [7:0]  CAPABILITY_LENGTH     = 8'h20;         // Offset to operational regs
  localparam logic [15:0] INTERFACE_VERSION     = 16'h0100;      // BCD interface revision

  // ----------------------------------------------------------------
  // Structural parameters fields
  // ----------------------------------------------------------------
  localparam int         SP_PORTS_LSB          = 0;             // Downstream port count
  localparam int         SP_PPC_BIT            = 4;             // Port power control
  localparam int         SP_PRR_BIT            = 7;             // Port routing rules
  localparam int         SP_NPCC_LSB           = 8;             // Ports per companion
  localparam int         SP_NCC_LSB            = 12;            // Companion count
  localparam int         SP_PIND_BIT           = 16;            // Port indicators
  localparam int         SP_DPN_LSB            = 20;            // Debug port number
  localparam logic [3:0]  PORT_COUNT            = 4'h1;
  localparam logic        PORT_POWER_CONTROL    = 1'b1;
  localparam logic        PORT_ROUTING_RULES    = 1'b0;
  localparam logic [3:0]  PORTS_PER_COMPANION   = 4'h0;
  localparam logic [3:0]  COMPANION_COUNT       = 4'h0;
  localparam logic        PORT_INDICATORS       = 1'b0;
  localparam logic [3:0]  DEBUG_PORT_NUMBER     = 4'h0;
  localparam logic [31:0] SP_RSVD_MASK          = 32'hFF0E_0060; // Reserved bits

  // ----------------------------------------------------------------
  // Capability parameters fields
  // ----------------------------------------------------------------
  localparam int         CP_PROGRAMMABLE_FRAME_LIST_FLAG_BIT           = 1;             // Programmable frame list
  localparam int         CP_ASYNC_PARK_CAPABILITY_BIT           = 2;             // Async park capability
  localparam int         CP_IST_LSB            = 4;             // Iso schedule threshold
  localparam int         CP_EXTENDED_CAPABILITY_POINTER_LSB           = 8;             // Extended cap pointer
  localparam logic        PROG_FRAME_LIST_FLAG  = 1'b1;
  localparam logic        ASYNC_PARK_CAPABILITY = 1'b1;
  localparam logic [3:0]  ISO_SCHEDULE_THRESH   = 4'h8;
  localparam logic [7:0]  EXT_CAPABILITY_PTR    = 8'h00;
  localparam logic [31:0] CP_RSVD_MASK          = 32'hFFFF_0009; // Reserved bits
  localparam logic [31:0] W0_RSVD_MASK          = 32'h0000_FF00; // Byte at 0001h

  // ----------------------------------------------------------------
  // Bus front end states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    USBC_ST_IDLE  = 2'b00,  // No access in progress
    USBC_ST_READ  = 2'b01,  // Driving read data
    USBC_ST_WRITE = 2'b10   // Swallowing a write
  } usbc_state_e;

endpackage

// [rtl/usbc_cap_rom.sv]
// Fixed capability words, selected by word index.
// Assumes the caller qualifies the index with the capability space.
`timescale 1ns/1ps
module usbc_cap_rom
  import usbc_cap_pkg::*;
#(
  parameter logic [3:0] NUM_PORTS = PORT_COUNT  // Downstream port count
)
(
  input  wire logic [2:0]  word_idx_i,   // Byte address bits 4 to 2
  output logic      [31:0] word_o        // Constant word at that index
);

  // ----------------------------------------------------------------
  // Word assembly
  // ----------------------------------------------------------------
  // Fields are placed into an all-zero word, so reserved bits read zero
  always_comb
  begin
    word_o = '0;
    if (word_idx_i == OFF_CAPABILITY_LENGTH[4:2])
    begin
      word_o[CAPLEN_LSB +: 8]   = CAPABILITY_LENGTH;
      word_o[VERSION_LSB +: 16] = INTERFACE_VERSION;
    end
    else if (word_idx_i == OFF_STRUCTURAL_PARAMS[4:2])
    begin
      word_o[SP_PORTS_LSB +: 4] = NUM_PORTS;
      word_o[SP_PPC_BIT]        = PORT_POWER_CONTROL;
      word_o[SP_PRR_BIT]        = PORT_ROUTING_RULES;
      word_o[SP_NPCC_LSB +: 4]  = PORTS_PER_COMPANION;
      word_o[SP_NCC_LSB +: 4]   = COMPANION_COUNT;
      word_o[SP_PIND_BIT]       = PORT_INDICATORS;
      word_o[SP_DPN_LSB +: 4]   = DEBUG_PORT_NUMBER;
    end
    else if (word_idx_i == OFF_CAPABILITY_PARAMS[4:2])
    begin
      word_o[CP_PROGRAMMABLE_FRAME_LIST_FLAG_BIT]       = PROG_FRAME_LIST_FLAG;
      word_o[CP_ASYNC_PARK_CAPABILITY_BIT]       = ASYNC_PARK_CAPABILITY;
      word_o[CP_IST_LSB +: 4]   = ISO_SCHEDULE_THRESH;
      word_o[CP_EXTENDED_CAPABILITY_POINTER_LSB +: 8]  = EXT_CAPABILITY_PTR;
    end
  end

endmodule // usbc_cap_rom

// [rtl/usbc_lane_sel.sv]
// Data lane steering for 32-bit or 16-bit processor buses.
// Assumes a 16-bit bus reads the halfword named by byte address bit 1.
`timescale 1ns/1ps
module usbc_lane_sel
(
  input  wire logic [31:0] word_i,       // Full register word
  input  wire logic        half_sel_i,   // Byte address bit 1
  input  wire logic        bus_16bit_i,  // High for a 16-bit data bus
  output logic      [31:0] data_o        // Value for the data pins
);

  // ----------------------------------------------------------------
  // Lane select
  // ----------------------------------------------------------------
  // On a 16-bit bus the upper pins carry zero so no stale half leaks
  always_comb
  begin
    if (!bus_16bit_i)
      data_o = word_i;
    else if (half_sel_i)
      data_o = {16'h0000, word_i[31:16]};
    else
      data_o = {16'h0000, word_i[15:0]};
  end

endmodule // usbc_lane_sel

// [rtl/usbc_cap_regs.sv]
// Read-only capability register group of the host controller.
// Assumes strobes arrive synchronous to sys_clk_i; other register groups
// answer outside byte addresses 0000h to 001Fh on the same data pins.
`timescale 1ns/1ps
module usbc_cap_regs
  import usbc_cap_pkg::*;
#(
  parameter logic [3:0] NUM_PORTS = PORT_COUNT  // Downstream port count
)
(
  input  wire logic        sys_clk_i,            // System clock, 50 MHz
  input  wire logic        sys_rst_i,            // Asynchronous reset, high
  input  wire logic        cs_n_i,               // Chip select, low
  input  wire logic        rd_n_i,               // Read strobe, low
  input  wire logic        wr_n_i,               // Write strobe, low
  input  wire logic [17:1] addr_i,               // Halfword address pins
  input  wire logic [31:0] data_i,               // Write data, discarded
  input  wire logic        bus_16bit_i,          // High for 16-bit bus
  output logic      [31:0] data_o,               // Read data
  output logic             data_oe_o,            // High while driving data
  output logic             prog_frame_list_o     // Frame list size is settable
);

  import usbc_cap_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [17:0] byte_addr;       // Byte address of the access
  logic        cap_space;       // Access falls in this group
  logic        rd_act;          // Read to this group in progress
  logic        wr_act;          // Write to this group in progress
  logic [31:0] rom_word;        // Constant word at this address
  logic [31:0] lane_data;       // Word steered to the data pins
  logic        write_seen;      // Write data present, kept only to mark use

  assign byte_addr  = {addr_i, 1'b0};
  // Anything at or above the operational base belongs to other groups
  assign cap_space  = (byte_addr < CAP_SPACE_END);
  assign rd_act     = !cs_n_i && !rd_n_i && cap_space;
  assign wr_act     = !cs_n_i && !wr_n_i && cap_space;
  assign write_seen = |data_i;

  // ----------------------------------------------------------------
  // Constant words and lane steering
  // ----------------------------------------------------------------
  // Word index taken from the byte address
  usbc_cap_rom #(
    .NUM_PORTS (NUM_PORTS)
  ) u_rom (
    .word_idx_i (byte_addr[4:2]),
    .word_o     (rom_word)
  );

  // Halfword steering for the 16-bit bus
  usbc_lane_sel u_lane (
    .word_i      (rom_word),
    .half_sel_i  (byte_addr[1]),
    .bus_16bit_i (bus_16bit_i),
    .data_o      (lane_data)
  );

  // ----------------------------------------------------------------
  // Bus front end state
  // ----------------------------------------------------------------
  usbc_state_e state_reg;       // Current access phase
  usbc_state_e state_next;
  logic [31:0] data_reg;        // Registered read data
  logic [31:0] data_next;
  logic        oe_reg;          // Registered output enable
  logic        oe_next;
  logic        pfl_reg;         // Registered frame list flag
  logic        pfl_next;

  // Next-state logic; data follows the address while the read lasts so a
  // late address settle still lands on the right word
  always_comb
  begin
    state_next = state_reg;
    data_next  = data_reg;
    oe_next    = oe_reg;
    // Frame list flag is a fixed one for the command logic
    pfl_next   = PROG_FRAME_LIST_FLAG;
    case (state_reg)
      USBC_ST_IDLE:
      begin
        if (rd_act)
        begin
          // Read wins if both strobes are low at once
          state_next = USBC_ST_READ;
          data_next  = lane_data;
          oe_next    = 1'b1;
        end
        else if (wr_act)
        begin
          state_next = USBC_ST_WRITE;
        end
      end
      USBC_ST_READ:
      begin
        if (rd_act)
        begin
          data_next = lane_data;
        end
        else
        begin
          // Release the pins one cycle after the strobe rises
          state_next = USBC_ST_IDLE;
          data_next  = '0;
          oe_next    = 1'b0;
        end
      end
      USBC_ST_WRITE:
      begin
        // Wait out the write strobe without touching any state
        if (!wr_act)
          state_next = USBC_ST_IDLE;
      end
      default:
      begin
        state_next = USBC_ST_IDLE;
        data_next  = '0;
        oe_next    = 1'b0;
      end
    endcase
  end

  // Registers only; every output comes straight from here
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= USBC_ST_IDLE;
      data_reg  <= '0;
      oe_reg    <= 1'b0;
      pfl_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      data_reg  <= data_next;
      oe_reg    <= oe_next;
      pfl_reg   <= pfl_next;
    end
  end

  assign data_o            = data_reg;
  assign data_oe_o         = oe_reg;
  assign prog_frame_list_o = pfl_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Every check is cut off while reset is held, since the pins are
  // forced low then whatever the bus is doing.
  // Shorthand for a 32-bit read of a given word being taken
  logic rd_take;                // Read the front end will answer
  logic rd32_w0;                // Word zero read on a wide bus
  logic rd32_w1;                // Structural word read on a wide bus
  logic rd32_w2;                // Capability word read on a wide bus

  // A read arriving during a write phase is held off, so it is not a take
  assign rd_take = rd_act && state_reg != USBC_ST_WRITE;
  assign rd32_w0 = rd_take && !bus_16bit_i && byte_addr[4:2] == OFF_CAPABILITY_LENGTH[4:2];
  assign rd32_w1 = rd_take && !bus_16bit_i && byte_addr[4:2] == OFF_STRUCTURAL_PARAMS[4:2];
  assign rd32_w2 = rd_take && !bus_16bit_i && byte_addr[4:2] == OFF_CAPABILITY_PARAMS[4:2];

  a_version_value: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd32_w0 |=> data_oe_o && data_o[31:16] == 16'h0100)
    else $error("version halfword wrong");

  a_cap_length: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd32_w0 |=> data_o[7:0] == 8'h20)
    else $error("capability length wrong");

  a_port_count: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd32_w1 |=> data_o[3:0] == NUM_PORTS)
    else $error("port count wrong");

  a_power_ctrl: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd32_w1 |=> data_o[4])
    else $error("port power control not reported");

  a_struct_zero: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd32_w1 |=> data_o[23:20] == 4'h0 && !data_o[16] && data_o[15:7] == 9'h000)
    else $error("structural zero fields set");

  a_struct_word: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd32_w1 |=> data_o == {28'h0000001, NUM_PORTS})
    else $error("structural word wrong");

  a_cap_word: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd32_w2 |=> data_o == 32'h0000_0086)
    else $error("capability word wrong");

  a_ext_pointer: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd32_w2 |=> data_o[15:8] == 8'h00)
    else $error("extended pointer nonzero");

  a_iso_thresh: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd32_w2 |=> data_o[7:4] == 4'b1000)
    else $error("iso threshold wrong");

  a_async_park: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd32_w2 |=> data_o[2])
    else $error("park capability not reported");

  // Flag on pins and on the side output agree
  a_frame_flag: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd32_w2 |=> data_o[1] && prog_frame_list_o)
    else $error("frame list flag not set");

  // Reserved bits of all three words
  a_rsvd_zero: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (rd32_w0 |=> (data_o & W0_RSVD_MASK) == '0) and
    (rd32_w1 |=> (data_o & SP_RSVD_MASK) == '0) and
    (rd32_w2 |=> (data_o & CP_RSVD_MASK) == '0))
    else $error("reserved bit set");

  // Narrow bus keeps upper pins quiet, high half on bit 1
  a_half_lane: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd_take && bus_16bit_i && byte_addr[1] && byte_addr[4:2] == 3'h0
    |=> data_o == 32'h0000_0100)
    else $error("16-bit lane wrong");

  // A write from idle leaves the pins undriven and moves to the write phase
  a_write_ignored: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    state_reg == USBC_ST_IDLE && wr_act && !rd_act && write_seen
    |=> !data_oe_o [*1] ##0 state_reg == USBC_ST_WRITE)
    else $error("write not ignored");

  // Pins released the cycle after the read ends
  a_oe_release: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    data_oe_o && !rd_act |=> !data_oe_o && data_o == '0)
    else $error("pins not released");

  // Reads outside this group never drive the pins
  a_outside_quiet: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !cs_n_i && !rd_n_i && !cap_space && !data_oe_o |=> !data_oe_o)
    else $error("pins driven outside the group");

  // Taken read answers one cycle later with the steered word
  a_read_answer: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd_take |=> data_oe_o && data_o == $past(lane_data))
    else $error("read answer wrong");

  // Upper pins stay zero on a 16-bit bus
  a_narrow_upper: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd_take && bus_16bit_i |=> data_o[31:16] == 16'h0000)
    else $error("upper pins set on 16-bit bus");

  // Write phase leaves the pins released and zero
  a_write_quiet: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    state_reg == USBC_ST_WRITE |-> !data_oe_o && data_o == '0)
    else $error("pins driven during write");

  // Frame list flag stays set once reset has gone
  a_flag_steady: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !$past(sys_rst_i) |-> prog_frame_list_o)
    else $error("frame list flag dropped");

endmodule // usbc_cap_regs

// [test/usbc_cap_regs_tb_top.sv]
// Self-checking bench for the capability register group.
// Assumes the design answers reads one clock after the taking edge and
// drives nothing for writes or for addresses outside 0000h to 001Fh.
`timescale 1ns/1ps

// One comparison: counts it, reports a mismatch at once
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module usbc_cap_regs_tb_top;
  import usbc_cap_pkg::*;

  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  logic        sys_clk_i = 1'b0;  // 50 MHz clock
  logic        sys_rst_i;         // Asynchronous reset, high
  logic        cs_n_i;            // Chip select, low
  logic        rd_n_i;            // Read strobe, low
  logic        wr_n_i;            // Write strobe, low
  logic [17:1] addr_i;            // Halfword address
  logic [31:0] data_i;            // Write data
  logic        bus_16bit_i;       // 16-bit bus mode
  logic [31:0] data_o;            // Read data
  logic        data_oe_o;         // Data pins driven
  logic        prog_frame_list_o; // Frame list flag
  int          error_cnt = 0;     // Mismatches
  int          n_tests = 0;       // Comparisons made
  int          cyc_cnt = 0;       // Cycles since start
  int          seed = 32'h28d1;   // Fixed seed, repeatable runs
  logic [31:0] exp_q[$];          // Expected words of a held read
  localparam int CYC_LIMIT = 4000; // Whole run needs well under this

  // ----------------------------------------------------------------
  // Clock, timeout and design
  // ----------------------------------------------------------------
  always #10 sys_clk_i = ~sys_clk_i;

  // A hang counts as a mismatch and ends in the same report
  always @(posedge sys_clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == CYC_LIMIT)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  usbc_cap_regs i_usbc_cap_regs (
    .sys_clk_i         (sys_clk_i),
    .sys_rst_i         (sys_rst_i),
    .cs_n_i            (cs_n_i),
    .rd_n_i            (rd_n_i),
    .wr_n_i            (wr_n_i),
    .addr_i            (addr_i),
    .data_i            (data_i),
    .bus_16bit_i       (bus_16bit_i),
    .data_o            (data_o),
    .data_oe_o         (data_oe_o),
    .prog_frame_list_o (prog_frame_list_o)
  );

  // ----------------------------------------------------------------
  // Reference model, built from the field values with plain integers
  // ----------------------------------------------------------------
  function automatic logic [31:0] model_rd(input logic [17:0] ba, input logic b16);
    int w;
    w = 0;
    // Word zero: length byte 20h, version 0100h in the upper half
    if (ba[4:2] == 3'd0)
      w = 32'h20 + (32'h0100 << 16);
    // Structural word: one port, power control bit 4, rest zero
    if (ba[4:2] == 3'd1)
      w = 1 + (1 << 4);
    // Capability word: threshold 8 at 7..4, park bit 2, frame list bit 1
    if (ba[4:2] == 3'd2)
      w = (8 << 4) + (1 << 2) + (1 << 1);
    // A 16-bit bus sees one half, selected by byte address bit 1
    if (b16)
      w = ba[1] ? ((w >> 16) & 32'hFFFF) : (w & 32'hFFFF);
    return 32'(w);
  endfunction

  // ----------------------------------------------------------------
  // Bus tasks; every drive lands 1 ns after a rising edge
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask

  // Single read, then release and check that the pins are let go
  task automatic rd_chk(input logic [17:0] ba, input logic b16);
    tick();
    bus_16bit_i = b16;
    cs_n_i      = 1'b0;
    rd_n_i      = 1'b0;
    addr_i      = ba[17:1];
    tick();
    if (ba < 18'h00020)
    begin
      `CHK(data_oe_o, 1'b1)
      `CHK(data_o, model_rd(ba, b16))
    end
    else
      `CHK(data_oe_o, 1'b0)
    cs_n_i = 1'b1;
    rd_n_i = 1'b1;
    addr_i = 17'($random(seed));
    tick();
    `CHK(data_oe_o, 1'b0)
    `CHK(data_o, 32'h0000_0000)
  endtask

  // Halfword write of random data on a 16-bit bus; reserved bits go as
  // zero, as software must write them. The pins stay quiet throughout.
  task automatic wr_chk(input logic [17:0] ba);
    logic [31:0] rsv;
    logic [15:0] hm;
    rsv = (ba[4:2] == 3'd0) ? W0_RSVD_MASK :
          (ba[4:2] == 3'd1) ? SP_RSVD_MASK :
          (ba[4:2] == 3'd2) ? CP_RSVD_MASK : 32'hFFFF_FFFF;
    hm  = ba[1] ? rsv[31:16] : rsv[15:0];
    tick();
    bus_16bit_i = 1'b1;
    cs_n_i      = 1'b0;
    wr_n_i      = 1'b0;
    addr_i      = ba[17:1];
    data_i      = {16'h0000, 16'($random(seed)) & ~hm};
    repeat (2)
    begin
      tick();
      `CHK(data_oe_o, 1'b0)
    end
    cs_n_i = 1'b1;
    wr_n_i = 1'b1;
    tick();
    `CHK(data_oe_o, 1'b0)
  endtask

  // Held read with the address moving every cycle: data lags one cycle
  task automatic stream(input logic b16, input int n);
    logic [17:0] ba;
    ba = {13'h0, 4'($random(seed)), 1'b0};
    tick();
    bus_16bit_i = b16;
    cs_n_i      = 1'b0;
    rd_n_i      = 1'b0;
    addr_i      = ba[17:1];
    exp_q.push_back(model_rd(ba, b16));
    for (int i = 0; i < n; i++)
    begin
      tick();
      `CHK(data_o, exp_q.pop_front())
      ba     = {13'h0, 4'($random(seed)), 1'b0};
      addr_i = ba[17:1];
      exp_q.push_back(model_rd(ba, b16));
    end
    cs_n_i = 1'b1;
    rd_n_i = 1'b1;
    exp_q.delete();
    tick();
    `CHK(data_oe_o, 1'b0)
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst_i   = 1'b1;
    cs_n_i      = 1'b1;
    rd_n_i      = 1'b1;
    wr_n_i      = 1'b1;
    addr_i      = '0;
    data_i      = '0;
    bus_16bit_i = 1'b0;
    repeat (5) tick();
    // Quiet pins and a cleared flag while reset is held
    `CHK({data_oe_o, prog_frame_list_o, data_o}, 34'h0)
    sys_rst_i = 1'b0;
    tick();
    `CHK(prog_frame_list_o, 1'b1)
    // Every word on a 32-bit bus, every half on a 16-bit bus
    for (int a = 0; a < 32; a += 4)
      rd_chk(18'(a), 1'b0);
    for (int a = 0; a < 32; a += 2)
      rd_chk(18'(a), 1'b1);
    // Writes everywhere, then everything must read as before
    for (int a = 0; a < 32; a += 2)
      wr_chk(18'(a));
    for (int a = 0; a < 32; a += 4)
      rd_chk(18'(a), 1'b0);
    `CHK(prog_frame_list_o, 1'b1)
    // Both strobes low: the read must win
    tick();
    cs_n_i = 1'b0;
    rd_n_i = 1'b0;
    wr_n_i = 1'b0;
    addr_i = 17'h00004;
    data_i = $random(seed) & ~CP_RSVD_MASK;
    tick();
    `CHK(data_o, model_rd(18'h00008, 1'b0))
    cs_n_i = 1'b1;
    rd_n_i = 1'b1;
    wr_n_i = 1'b1;
    // Operational space belongs to other groups: never driven here
    repeat (6)
      rd_chk(18'($random(seed)) | 18'h00020, 1'b0);
    stream(1'b0, 20);
    stream(1'b1, 20);
    // Reset in mid-read releases the pins at once
    tick();
    cs_n_i = 1'b0;
    rd_n_i = 1'b0;
    addr_i = 17'h00002;
    tick();
    `CHK(data_oe_o, 1'b1)
    sys_rst_i = 1'b1;
    cs_n_i    = 1'b1;
    rd_n_i    = 1'b1;
    #1;
    `CHK({data_oe_o, prog_frame_list_o, data_o}, 34'h0)
    tick();
    sys_rst_i = 1'b0;
    tick();
    `CHK(prog_frame_list_o, 1'b1)
    rd_chk(18'h00008, 1'b0);
    report_and_stop();
  end
endmodule // usbc_cap_regs_tb_top
